/* File: design/cpi_pkg.sv */
// Package of constants and types for the configuration packet interpreter
package cpi_pkg;

	// ==========================================
	// Header layout
	localparam logic [2:0] CPI_TYPE_STD = 3'h1;
	localparam logic [2:0] CPI_TYPE_EXT = 3'h2;
	localparam logic [1:0] CPI_DIR_READ = 2'h1;
	localparam logic [1:0] CPI_DIR_WRITE = 2'h2;
	localparam int CPI_TYPE_HI = 31;
	localparam int CPI_TYPE_LO = 29;
	localparam int CPI_DIR_HI = 28;
	localparam int CPI_DIR_LO = 27;
	localparam int CPI_ADDR_HI = 16;
	localparam int CPI_ADDR_LO = 13;
	localparam int CPI_STD_CNT_HI = 10;
	localparam logic [31:0] CPI_STD_ZERO_MASK = 32'h07fe1800;
	localparam logic [31:0] CPI_EXT_ZERO_MASK = 32'h07e00000;
	localparam logic [31:0] CPI_EXT_CNT_MASK = 32'h001fffff;
	localparam logic [20:0] CPI_EXT_CNT_MAX = 21'h1fffff;

	// ==========================================
	// Register addresses
	localparam logic [3:0] CPI_A_CHECK = 4'h0;
	localparam logic [3:0] CPI_A_FADDR = 4'h1;
	localparam logic [3:0] CPI_A_FIN = 4'h2;
	localparam logic [3:0] CPI_A_FOUT = 4'h3;
	localparam logic [3:0] CPI_A_CMD = 4'h4;
	localparam logic [3:0] CPI_A_CTL = 4'h5;
	localparam logic [3:0] CPI_A_MASK = 4'h6;
	localparam logic [3:0] CPI_A_STAT = 4'h7;
	localparam logic [3:0] CPI_A_LEGACY_OUTPUT = 4'h8;
	localparam logic [3:0] CPI_A_OPT = 4'h9;
	localparam logic [3:0] CPI_A_FLEN = 4'hb;

	// ==========================================
	// Command codes and control fields
	localparam logic [3:0] CPI_CMD_FRAME_WRITE_CMD = 4'h1;
	localparam logic [3:0] CPI_CMD_LAST = 4'h3;
	localparam logic [3:0] CPI_CMD_FRAME_READBACK_CMD = 4'h4;
	localparam logic [3:0] CPI_CMD_RCRC = 4'h7;
	localparam logic [3:0] CPI_CMD_FORCE = 4'h8;
	localparam int CPI_CTL_KEEP_BIT = 6;
	localparam logic [31:0] CPI_RESET_WORD = 32'h00000000;

	typedef enum logic [1:0] {
		CPI_S_HEADER = 2'b00,
		CPI_S_EXT = 2'b01,
		CPI_S_DATA = 2'b10
	} cpi_state_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [1:0] dir;
	} cpi_op_s;

endpackage : cpi_pkg

/* File: design/cpi_interp.sv */
// Configuration packet interpreter with word input buffer and register file
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1: Headers, data and every register are 32-bit words.
// R2: Direction field 01 reads, 10 writes; only two operations.
// R3: Standard header: type 001, direction, zero bits, 4-bit address, 11-bit count.
// R4: A packet is one header followed by zero or more data words.
// R5: Standard count gives data words following header, 0 to 2047.
// R6: Count zero then extension word type 010, same direction, 21-bit count.
// R7: Fixed header bits must hold their values; variable bits set by host.
// R8: Address selects register; write-only, read-only and reserved addresses honoured.
// R9: Command acts when written to command register; drives state and globals.
// R10: Command re-executes each time frame address is loaded.
// R11: Words accepted from byte host port or JTAG port.
// R12: Host sends sync, check reset, length, options, mask, control, clock setting.
// R13: keep_host_port in control keeps the byte host port active.
// R14: Readback of all or part of configuration once configured.
// R15: Readback order: address, readback command, count, pad word, read frames.
// R16: Frame writes accepted during initial and partial reconfiguration.
// R17: Write order: address, write command, optional force, count, frames.
// R18: Code 0001 frame write, 0100 frame readback; both sequence frame shifting.
// R19: Code 1000 asserts global_force_high, forcing logic outputs to one.
// R20: Writes to read-only or reserved addresses ignored; bad reads return zero.
module cpi_interp
	import cpi_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic host_valid,
	output logic host_ready,
	input wire logic [31:0] host_word,
	input wire logic jtag_valid,
	output logic jtag_ready,
	input wire logic [31:0] jtag_word,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [31:0] rd_word,
	input wire logic [31:0] frame_rd_data,
	output logic frame_wr_strobe,
	output logic [31:0] frame_wr_data,
	output logic frame_rd_strobe,
	output logic [31:0] frame_addr_out,
	output logic global_force_high,
	output logic keep_host_port,
	output logic header_error
);

	// ==========================================
	// Port selection and two-entry input buffer
	logic [31:0] buf_mem [2];
	logic buf_wp_reg, buf_rp_reg;
	logic [1:0] buf_cnt_reg;
	logic in_valid, in_ready, buf_out_valid, buf_take;
	logic [31:0] in_word, cur_word;

	// Host port has priority; JTAG waits while the host port offers a word
	assign in_valid = host_valid | jtag_valid; // R11
	assign in_word = host_valid ? host_word : jtag_word;
	assign in_ready = (buf_cnt_reg != 2'h2);
	assign host_ready = in_ready;
	assign jtag_ready = in_ready & ~host_valid;
	assign buf_out_valid = (buf_cnt_reg != 2'h0);
	assign cur_word = buf_mem[buf_rp_reg];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			if (in_valid && in_ready)
				buf_wp_reg <= ~buf_wp_reg;
			if (buf_take)
				buf_rp_reg <= ~buf_rp_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, in_valid & in_ready} - {1'b0, buf_take};
		end
	end

	always_ff @(posedge clock) begin
		if (in_valid && in_ready)
			buf_mem[buf_wp_reg] <= in_word;
	end

	// ==========================================
	// Packet parser
	cpi_state_e state_reg;
	cpi_op_s op_reg;
	logic [20:0] count_reg;
	logic hdr_ok, ext_ok, is_data, is_write, is_read;
	logic [31:0] read_mux;

	assign hdr_ok = (cur_word[CPI_TYPE_HI:CPI_TYPE_LO] == CPI_TYPE_STD)
		&& ((cur_word & CPI_STD_ZERO_MASK) == CPI_RESET_WORD)
		&& (cur_word[CPI_DIR_HI:CPI_DIR_LO] == CPI_DIR_READ
		|| cur_word[CPI_DIR_HI:CPI_DIR_LO] == CPI_DIR_WRITE); // R2 R3 R7
	assign ext_ok = (cur_word[CPI_TYPE_HI:CPI_TYPE_LO] == CPI_TYPE_EXT)
		&& ((cur_word & CPI_EXT_ZERO_MASK) == CPI_RESET_WORD)
		&& (cur_word[CPI_DIR_HI:CPI_DIR_LO] == op_reg.dir); // R6 R7
	assign is_data = (state_reg == CPI_S_DATA);
	assign is_write = is_data && op_reg.dir == CPI_DIR_WRITE;
	assign is_read = is_data && op_reg.dir == CPI_DIR_READ;
	// Reads stall until the answer slot is free, so no word is lost
	assign buf_take = buf_out_valid && !(is_read && rd_valid && !rd_ready);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= CPI_S_HEADER;
			op_reg <= '0;
			count_reg <= '0;
			header_error <= 1'b0;
		end else if (buf_take) begin
			unique case (state_reg)
				CPI_S_HEADER: begin // R4
					// Non-header words (pad, sync) are skipped between packets
					if (hdr_ok) begin
						op_reg.addr <= cur_word[CPI_ADDR_HI:CPI_ADDR_LO]; // R8
						op_reg.dir <= cur_word[CPI_DIR_HI:CPI_DIR_LO];
						count_reg <= {10'h000, cur_word[CPI_STD_CNT_HI:0]}; // R5
						if (cur_word[CPI_STD_CNT_HI:0] == 11'h000)
							state_reg <= CPI_S_EXT; // R6
						else
							state_reg <= CPI_S_DATA;
					end
				end
				CPI_S_EXT: begin
					if (ext_ok && cur_word[20:0] != 21'h000000
						&& cur_word[20:0] <= CPI_EXT_CNT_MAX) begin
						count_reg <= cur_word[20:0] & CPI_EXT_CNT_MASK[20:0]; // R6
						state_reg <= CPI_S_DATA;
					end else if (hdr_ok) begin
						// Zero-count packet followed by a fresh header
						op_reg.addr <= cur_word[CPI_ADDR_HI:CPI_ADDR_LO];
						op_reg.dir <= cur_word[CPI_DIR_HI:CPI_DIR_LO];
						count_reg <= {10'h000, cur_word[CPI_STD_CNT_HI:0]};
						state_reg <= (cur_word[CPI_STD_CNT_HI:0] == 11'h000) ? CPI_S_EXT
							: CPI_S_DATA;
					end else begin
						header_error <= 1'b1;
						state_reg <= CPI_S_HEADER;
					end
				end
				CPI_S_DATA: begin
					count_reg <= count_reg - 21'h000001;
					if (count_reg == 21'h000001)
						state_reg <= CPI_S_HEADER;
				end
			endcase
		end
	end

	// ==========================================
	// Configuration registers
	logic [31:0] check_value_reg, frame_address_reg, command_reg_reg, control_reg_reg;
	logic [31:0] control_write_enables_reg, legacy_output_reg, configuration_options_reg;
	logic [31:0] frame_length_reg, frame_output_cnt_reg, frame_input_cnt_reg;
	logic configured_reg, cmd_exec, wr_word;
	logic [31:0] status_word;

	assign wr_word = buf_take && is_write;
	// Command runs when written and again on every new frame address
	assign cmd_exec = wr_word && (op_reg.addr == CPI_A_CMD || op_reg.addr == CPI_A_FADDR); // R9 R10

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			check_value_reg <= CPI_RESET_WORD;
			frame_address_reg <= CPI_RESET_WORD;
			command_reg_reg <= CPI_RESET_WORD;
			control_reg_reg <= CPI_RESET_WORD;
			control_write_enables_reg <= CPI_RESET_WORD;
			legacy_output_reg <= CPI_RESET_WORD;
			configuration_options_reg <= CPI_RESET_WORD;
			frame_length_reg <= CPI_RESET_WORD;
		end else if (wr_word) begin
			// Read-only and reserved targets fall through untouched
			unique case (op_reg.addr) // R8 R20
				CPI_A_CHECK: check_value_reg <= cur_word;
				CPI_A_FADDR: frame_address_reg <= cur_word;
				CPI_A_CMD: command_reg_reg <= cur_word;
				CPI_A_CTL: control_reg_reg <= (control_reg_reg & ~control_write_enables_reg)
					| (cur_word & control_write_enables_reg); // R13
				CPI_A_MASK: control_write_enables_reg <= cur_word;
				CPI_A_LEGACY_OUTPUT: legacy_output_reg <= cur_word;
				CPI_A_OPT: configuration_options_reg <= cur_word;
				CPI_A_FLEN: frame_length_reg <= cur_word;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Command execution and frame data path
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			global_force_high <= 1'b0;
			configured_reg <= 1'b0;
			frame_output_cnt_reg <= CPI_RESET_WORD;
			frame_input_cnt_reg <= CPI_RESET_WORD;
		end else begin
			if (cmd_exec) begin
				unique case (op_reg.addr == CPI_A_CMD ? cur_word[3:0] : command_reg_reg[3:0])
					CPI_CMD_FORCE: global_force_high <= 1'b1; // R19
					CPI_CMD_LAST: global_force_high <= 1'b0;
					default: ;
				endcase
			end
			// Frame-data write counts words pushed through frame_input
			if (wr_word && op_reg.addr == CPI_A_FIN
				&& command_reg_reg[3:0] == CPI_CMD_FRAME_WRITE_CMD) begin // R16 R18
				frame_input_cnt_reg <= frame_input_cnt_reg + 32'h00000001;
				configured_reg <= 1'b1;
			end
			if (buf_take && is_read && op_reg.addr == CPI_A_FOUT)
				frame_output_cnt_reg <= frame_output_cnt_reg + 32'h00000001;
		end
	end

	assign frame_wr_strobe = wr_word && op_reg.addr == CPI_A_FIN
		&& command_reg_reg[3:0] == CPI_CMD_FRAME_WRITE_CMD; // R18
	assign frame_wr_data = cur_word;
	assign frame_rd_strobe = buf_take && is_read && op_reg.addr == CPI_A_FOUT
		&& command_reg_reg[3:0] == CPI_CMD_FRAME_READBACK_CMD; // R14 R18
	assign frame_addr_out = frame_address_reg;
	assign keep_host_port = control_reg_reg[CPI_CTL_KEEP_BIT]; // R13

	assign status_word = {27'h0000000, header_error, configured_reg, global_force_high,
		state_reg};

	// ==========================================
	// Read answers
	always_comb begin
		unique case (op_reg.addr) // R20
			CPI_A_CHECK: read_mux = check_value_reg;
			CPI_A_FADDR: read_mux = frame_address_reg;
			CPI_A_FOUT: read_mux = frame_rd_data;
			CPI_A_CMD: read_mux = command_reg_reg;
			CPI_A_CTL: read_mux = control_reg_reg;
			CPI_A_MASK: read_mux = control_write_enables_reg;
			CPI_A_STAT: read_mux = status_word;
			CPI_A_OPT: read_mux = configuration_options_reg;
			CPI_A_FLEN: read_mux = frame_length_reg;
			default: read_mux = CPI_RESET_WORD;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_valid <= 1'b0;
			rd_word <= CPI_RESET_WORD;
		end else begin
			if (buf_take && is_read) begin // R1
				rd_valid <= 1'b1;
				rd_word <= read_mux;
			end else if (rd_ready)
				rd_valid <= 1'b0;
		end
	end

	// ==========================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	read_answer_a: assert property (buf_take && is_read |=> rd_valid) // R2
		else $error("read word gave no answer");
	ext_follows_a: assert property (buf_take && state_reg == CPI_S_HEADER && hdr_ok
		&& cur_word[CPI_STD_CNT_HI:0] == 11'h000 |=> state_reg == CPI_S_EXT) // R6
		else $error("zero count did not await extension");
	std_count_a: assert property (buf_take && state_reg == CPI_S_HEADER && hdr_ok
		&& cur_word[CPI_STD_CNT_HI:0] != 11'h000
		|=> count_reg == {10'h000, $past(cur_word[CPI_STD_CNT_HI:0])}) // R5
		else $error("standard count not loaded");
	bad_hdr_a: assert property (buf_take && state_reg == CPI_S_HEADER && !hdr_ok
		|=> state_reg == CPI_S_HEADER) // R3
		else $error("malformed header accepted");
	ro_ignore_a: assert property (wr_word && op_reg.addr == CPI_A_STAT
		|=> $stable(control_reg_reg) && $stable(command_reg_reg)) // R20
		else $error("read-only write changed state");
	force_high_a: assert property (cmd_exec && op_reg.addr == CPI_A_CMD
		&& cur_word[3:0] == CPI_CMD_FORCE |=> global_force_high) // R19
		else $error("force command ignored");
	reexec_a: assert property (wr_word && op_reg.addr == CPI_A_FADDR
		&& command_reg_reg[3:0] == CPI_CMD_FORCE |=> global_force_high) // R10
		else $error("command not re-executed");
	frame_wr_a: assert property (frame_wr_strobe // R16 R18
		|=> configured_reg
		&& frame_input_cnt_reg == $past(frame_input_cnt_reg) + 32'h00000001)
		else $error("frame write not counted");
	keep_port_a: assert property (wr_word && op_reg.addr == CPI_A_CTL // R13
		&& control_write_enables_reg[CPI_CTL_KEEP_BIT]
		|=> keep_host_port == $past(cur_word[CPI_CTL_KEEP_BIT]))
		else $error("keep flag not written");
	no_loss_a: assert property (in_valid && in_ready && buf_cnt_reg == 2'h0
		|=> buf_out_valid && cur_word == $past(in_word))
		else $error("buffered word lost");

	cov_write_c: cover property (frame_wr_strobe);
	cov_read_c: cover property (frame_rd_strobe ##[1:4] rd_valid);
	cov_ext_c: cover property (state_reg == CPI_S_EXT ##1 state_reg == CPI_S_DATA);
	cov_full_c: cover property (buf_cnt_reg == 2'h2);

endmodule : cpi_interp

`default_nettype wire

/* File: tb/cpi_host_model.sv */
// Host-side model: word source for the host port and sink for read answers
`timescale 1ns/100ps
`default_nettype none
module cpi_host_model
	import cpi_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic host_ready,
	input wire logic rd_valid,
	input wire logic [31:0] rd_word,
	output logic host_valid,
	output logic [31:0] host_word,
	output logic rd_ready
);
	logic [31:0] tx_q[$];
	logic [31:0] rx_q[$];
	logic stall;
	initial begin
		host_valid = 1'b0;
		host_word = 32'h0;
		rd_ready = 1'b1;
		stall = 1'b0;
	end
	// ==========================================
	// Whole packets queued by the bench in host order
	task automatic push(input logic [31:0] w);
		tx_q.push_back(w);
	endtask : push
	// ==========================================
	// A word leaves only at the edge that sees ready; an idle bus alternates the last word with its inverse
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			host_valid <= 1'b0;
		end else begin
			if (host_valid && host_ready) begin
				tx_q.delete(0);
			end
			host_valid <= (tx_q.size() != 0);
			host_word <= (tx_q.size() != 0) ? tx_q[0] : ~host_word;
			if (rd_valid && rd_ready) begin
				rx_q.push_back(rd_word);
			end
			rd_ready <= !stall;
		end
	end
endmodule : cpi_host_model
`default_nettype wire

/* File: tb/cpi_interp_bench.sv */
// Self-checking bench for the configuration packet interpreter
`timescale 1ns/100ps
`default_nettype none
module cpi_interp_bench;
	import cpi_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic jtag_valid = 1'b0;
	logic [31:0] jtag_word = 32'h0;
	logic [31:0] frame_rd_data = 32'hc0ffee00;
	logic host_valid, host_ready, jtag_ready, rd_valid, rd_ready;
	logic [31:0] host_word, rd_word, frame_wr_data, frame_addr_out;
	logic frame_wr_strobe, frame_rd_strobe, global_force_high, keep_host_port, header_error;
	int err_total = 0;
	int n_checks = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	logic [31:0] last_wr = 32'h0;
	logic [31:0] got;
	typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} cpi_row_t;
	cpi_row_t rows[11];
	always #2.5 clock = ~clock;
	cpi_interp i_cpi_interp (.clock(clock), .rstn(rstn), .host_valid(host_valid),
		.host_ready(host_ready), .host_word(host_word), .jtag_valid(jtag_valid),
		.jtag_ready(jtag_ready), .jtag_word(jtag_word), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_word(rd_word), .frame_rd_data(frame_rd_data),
		.frame_wr_strobe(frame_wr_strobe), .frame_wr_data(frame_wr_data),
		.frame_rd_strobe(frame_rd_strobe), .frame_addr_out(frame_addr_out),
		.global_force_high(global_force_high), .keep_host_port(keep_host_port),
		.header_error(header_error));
	cpi_host_model i_cpi_host_model (.clock(clock), .rstn(rstn), .host_ready(host_ready),
		.rd_valid(rd_valid), .rd_word(rd_word), .host_valid(host_valid),
		.host_word(host_word), .rd_ready(rd_ready));
	always @(posedge clock) begin
		if (frame_wr_strobe === 1'b1) begin
			wr_cnt++;
			last_wr <= frame_wr_data;
		end
		if (frame_rd_strobe === 1'b1) begin
			rd_cnt++;
		end
	end
	// ==========================================
	// Word builders and checks
	function automatic logic [31:0] hdr(input logic [1:0] dir, input logic [3:0] a,
		input logic [10:0] cnt);
		return {3'h1, dir, 10'h0, a, 2'h0, cnt};
	endfunction : hdr
	function automatic logic [31:0] ext(input logic [1:0] dir, input logic [20:0] cnt);
		return {3'h2, dir, 6'h0, cnt};
	endfunction : ext
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t word %h expected %h", $time, g, e);
		end
	endtask : chk32
	task automatic chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t flag %b expected %b", $time, g, e);
		end
	endtask : chk1
	task automatic idle();
		for (int i = 0; i < 500 && i_cpi_host_model.tx_q.size() != 0; i++) @(posedge clock);
		repeat (8) @(posedge clock);
	endtask : idle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		i_cpi_host_model.push(hdr(2'b10, a, 11'h1));
		i_cpi_host_model.push(d);
		idle();
	endtask : wr
	// One dummy word stands behind a one-word read
	task automatic rd(input logic [3:0] a, output logic [31:0] g);
		i_cpi_host_model.push(hdr(2'b01, a, 11'h1));
		i_cpi_host_model.push(32'h0);
		for (int i = 0; i < 500 && i_cpi_host_model.rx_q.size() == 0; i++) @(posedge clock);
		g = (i_cpi_host_model.rx_q.size() != 0) ? i_cpi_host_model.rx_q.pop_front() : 'x;
	endtask : rd
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
	// ==========================================
	// Main sequence
	initial begin
		rows = '{'{4'h6, 32'hffffffff, 32'hffffffff}, '{4'h5, 32'h0000003c, 32'h0000003c},
			'{4'h0, 32'h12345678, 32'h12345678}, '{4'h1, 32'h00000abc, 32'h00000abc},
			'{4'h9, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{4'hb, 32'h00000010, 32'h00000010},
			'{4'h2, 32'h11111111, 32'h0}, '{4'h8, 32'h22222222, 32'h0},
			'{4'ha, 32'h33333333, 32'h0}, '{4'hf, 32'h44444444, 32'h0},
			'{4'h7, 32'h55555555, 32'h00000002}};
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd(4'h4, got);
		chk32(got, 32'h0);
		chk1(global_force_high, 1'b0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, got);
			chk32(got, rows[i].e);
		end
		chk32(wr_cnt, 0);
		wr(4'h4, 32'h8);
		chk1(global_force_high, 1'b1);
		wr(4'h1, 32'h80);
		chk1(global_force_high, 1'b1);
		wr(4'h4, 32'h3);
		chk1(global_force_high, 1'b0);
		wr(4'h5, 32'h40);
		chk1(keep_host_port, 1'b1);
		wr(4'h4, 32'h1);
		wr(4'h1, 32'h100);
		chk32(frame_addr_out, 32'h100);
		i_cpi_host_model.push(hdr(2'b10, 4'h2, 11'h0));
		i_cpi_host_model.push(ext(2'b10, 21'h3));
		for (int i = 1; i <= 3; i++) i_cpi_host_model.push(32'hf0 + i);
		idle();
		chk32(wr_cnt, 3);
		chk32(last_wr, 32'hf3);
		wr(4'h4, 32'h4);
		wr(4'h3, 32'h00000002);
		i_cpi_host_model.stall = 1'b1;
		i_cpi_host_model.push(hdr(2'b01, 4'h3, 11'h2));
		for (int i = 0; i < 4; i++) i_cpi_host_model.push(32'h0);
		repeat (20) @(posedge clock);
		chk1(rd_valid, 1'b1);
		chk1(host_ready, 1'b0);
		i_cpi_host_model.stall = 1'b0;
		idle();
		chk32(i_cpi_host_model.rx_q.size(), 2);
		chk32(i_cpi_host_model.rx_q.pop_front(), 32'hc0ffee00);
		chk32(rd_cnt, 2);
		i_cpi_host_model.rx_q.delete();
		@(posedge clock);
		jtag_valid <= 1'b1;
		jtag_word <= hdr(2'b10, 4'h0, 11'h1);
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 100; i++) begin
				@(posedge clock);
				if (jtag_ready) break;
			end
			jtag_word <= 32'h0badf00d;
		end
		jtag_valid <= 1'b0;
		rd(4'h0, got);
		chk32(got, 32'h0badf00d);
		i_cpi_host_model.push(hdr(2'b10, 4'h2, 11'h0));
		i_cpi_host_model.push(ext(2'b10, 21'h0));
		idle();
		chk1(header_error, 1'b1);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		chk1(header_error, 1'b0);
		chk1(keep_host_port, 1'b0);
		end_sim();
	end
endmodule : cpi_interp_bench
`default_nettype wire
